/* File: hw/acl_top.sv */
// configuration lock bits, trip registers and alert control
module acl_top (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // register access from the serial bus front end
  input  wire acl_pkg::acl_req_t req,
  output logic [15:0]            rd_data,
  // temperature comparison results
  input  wire acl_pkg::acl_cond_t cond,
  // alert pin
  output logic                   alert_o,
  output logic                   alert_oe_n,
  // stored thresholds for the comparator
  output logic [15:0]            upper_trip,
  output logic [15:0]            lower_trip,
  output logic [15:0]            crit_trip
);
  import acl_pkg::*;

  // all state of this module
  typedef struct packed {
    acl_cfg_t    cfg;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] crit;
  } acl_st_t;

  acl_st_t     st_q;      // registered state
  acl_st_t     st_d;      // next state
  logic        locked;    // either lock bit set
  logic        clear_req; // alert clear strobe
  logic        asserted;  // alert currently asserted
  logic        wr_cfg;    // write to configuration
  logic [15:0] trip_in;   // masked trip write data

  assign locked  = st_q.cfg.crit_lock | st_q.cfg.window_lock;
  assign wr_cfg  = req.wr && (req.addr == ACL_OFS_CONFIG);
  assign trip_in = req.data & ACL_TRIP_MASK;
  // write-only clear bit acts on the write, stores nothing
  assign clear_req = wr_cfg && req.data[ACL_BIT_ALERT_CLEAR];

  // register write decode
  always_comb begin
    st_d = st_q;
    if (wr_cfg) begin
      // locks set by one write, never cleared by software
      if (req.data[ACL_BIT_CRIT_LOCK]) begin
        st_d.cfg.crit_lock = 1'b1;
      end
      if (req.data[ACL_BIT_WINDOW_LOCK]) begin
        st_d.cfg.window_lock = 1'b1;
      end
      // frozen while locked; status bit write is dropped
      if (!locked) begin
        st_d.cfg.out_en    = req.data[ACL_BIT_OUT_EN];
        st_d.cfg.crit_only = req.data[ACL_BIT_CRIT_ONLY];
        st_d.cfg.polarity  = req.data[ACL_BIT_POLARITY];
        st_d.cfg.mode      = req.data[ACL_BIT_MODE];
      end
    end else if (req.wr && req.addr == ACL_OFS_UPPER) begin
      // locked write is accepted but discarded
      if (!st_q.cfg.window_lock) begin
        st_d.upper = trip_in;
      end
    end else if (req.wr && req.addr == ACL_OFS_LOWER) begin
      if (!st_q.cfg.window_lock) begin
        st_d.lower = trip_in;
      end
    end else if (req.wr && req.addr == ACL_OFS_CRIT) begin
      if (!st_q.cfg.crit_lock) begin
        st_d.crit = trip_in;
      end
    end
  end

  // state register, cleared only by power-on reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // locks and settings zero, thresholds at their reset value
      st_q <= '{cfg:   '0,
                upper: ACL_RST_TRIP,
                lower: ACL_RST_TRIP,
                crit:  ACL_RST_TRIP};
    end else begin
      st_q <= st_d;
    end
  end

  // read mux
  always_comb begin
    rd_data = 16'h0000;
    if (req.addr == ACL_OFS_CONFIG) begin
      rd_data[ACL_BIT_CRIT_LOCK]   = st_q.cfg.crit_lock;
      rd_data[ACL_BIT_WINDOW_LOCK] = st_q.cfg.window_lock;
      rd_data[ACL_BIT_ALERT_CLEAR] = 1'b0;
      rd_data[ACL_BIT_STATUS]      = asserted;
      rd_data[ACL_BIT_OUT_EN]      = st_q.cfg.out_en;
      rd_data[ACL_BIT_CRIT_ONLY]   = st_q.cfg.crit_only;
      rd_data[ACL_BIT_POLARITY]    = st_q.cfg.polarity;
      rd_data[ACL_BIT_MODE]        = st_q.cfg.mode;
    end else if (req.addr == ACL_OFS_UPPER) begin
      rd_data = st_q.upper;
    end else if (req.addr == ACL_OFS_LOWER) begin
      rd_data = st_q.lower;
    end else if (req.addr == ACL_OFS_CRIT) begin
      rd_data = st_q.crit;
    end
  end

  assign upper_trip = st_q.upper;
  assign lower_trip = st_q.lower;
  assign crit_trip  = st_q.crit;

  // alert generation
  acl_alert_gen acl_alert_gen_i (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .cfg        (st_q.cfg),
    .cond       (cond),
    .clear_req  (clear_req),
    .asserted   (asserted),
    .alert_o    (alert_o),
    .alert_oe_n (alert_oe_n)
  );
endmodule

/* File: hw/acl_pkg.sv */
// package: constants and carrier types of the alert configuration lock bank
package acl_pkg;
  // register offsets (8-bit pointer)
  localparam logic [7:0] ACL_OFS_CONFIG = 8'h01;
  localparam logic [7:0] ACL_OFS_UPPER  = 8'h02;
  localparam logic [7:0] ACL_OFS_LOWER  = 8'h03;
  localparam logic [7:0] ACL_OFS_CRIT   = 8'h04;
  // configuration field positions
  localparam int ACL_BIT_CRIT_LOCK   = 7;
  localparam int ACL_BIT_WINDOW_LOCK = 6;
  localparam int ACL_BIT_ALERT_CLEAR = 5;
  localparam int ACL_BIT_STATUS      = 4;
  localparam int ACL_BIT_OUT_EN      = 3;
  localparam int ACL_BIT_CRIT_ONLY   = 2;
  localparam int ACL_BIT_POLARITY    = 1;
  localparam int ACL_BIT_MODE        = 0;
  // trip registers keep bits 12:2 only
  localparam logic [15:0] ACL_TRIP_MASK = 16'h1FFC;
  // reset values
  localparam logic [15:0] ACL_RST_TRIP = 16'h0000;

  // register write/read request from the serial bus front end
  typedef struct packed {
    logic        wr;   // one-cycle write strobe
    logic [7:0]  addr; // register pointer
    logic [15:0] data; // write data
  } acl_req_t;

  // comparison results from the temperature logic
  typedef struct packed {
    logic above_window;
    logic below_window;
    logic above_crit;
  } acl_cond_t;

  // stored configuration bits
  typedef struct packed {
    logic crit_lock;
    logic window_lock;
    logic out_en;
    logic crit_only;
    logic polarity;
    logic mode;
  } acl_cfg_t;
endpackage

/* File: hw/acl_alert_gen.sv */
// alert source selection, interrupt latch and pin polarity
module acl_alert_gen (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // configuration and conditions
  input  wire acl_pkg::acl_cfg_t  cfg,
  input  wire acl_pkg::acl_cond_t cond,
  input  wire logic             clear_req,
  // results
  output logic                  asserted,
  output logic                  alert_o,
  output logic                  alert_oe_n
);
  import acl_pkg::*;

  // all state of this module
  typedef struct packed {
    logic pend;  // latched interrupt alert
    logic prev;  // previous source level, for edge detect
    logic act;   // registered assertion
  } acl_ag_st_t;

  acl_ag_st_t st_q;   // registered state
  acl_ag_st_t st_d;   // next state
  logic       src;    // selected alert source

  // next-state logic
  always_comb begin
    st_d = st_q;
    // critical only, or window plus critical
    if (cfg.crit_only) begin
      src = cond.above_crit;
    end else begin
      src = cond.above_crit | cond.above_window | cond.below_window;
    end
    st_d.prev = src;
    if (cfg.mode) begin
      // new event wins over a clear in the same cycle
      if (src && !st_q.prev) begin
        st_d.pend = 1'b1;
      end else if (clear_req) begin
        st_d.pend = 1'b0;
      end
      st_d.act = st_d.pend;
    end else begin
      // comparator mode follows the condition; clear ignored
      st_d.pend = 1'b0;
      st_d.act  = src;
    end
    // disabled output never asserts
    if (!cfg.out_en) begin
      st_d.act = 1'b0;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign asserted = st_q.act;
  // push-pull style: drive level, enable held low at all times
  assign alert_o    = st_q.act ~^ cfg.polarity;
  assign alert_oe_n = 1'b0;
endmodule

/* File: test/acl_monitor.sv */
// port checker of the alert configuration lock bank
module acl_monitor import acl_pkg::*; (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // register access and alert
  input wire acl_req_t    req,
  input wire logic [15:0] rd_data,
  input wire acl_cond_t   cond,
  input wire logic        alert_o,
  input wire logic        alert_oe_n,
  input wire logic [15:0] upper_trip,
  input wire logic [15:0] lower_trip,
  input wire logic [15:0] crit_trip
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic       ck_q, wk_q; // locks seen on the bus
  logic [3:0] lo_q;       // low config bits seen
  wire cfg_wr = req.wr && req.addr == ACL_OFS_CONFIG;
  wire cfg_rd = req.addr == ACL_OFS_CONFIG;
  wire lk     = ck_q || wk_q;
  // follow host writes to the configuration word
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {ck_q, wk_q, lo_q} <= 6'h00;
    end else if (cfg_wr) begin
      ck_q <= ck_q | req.data[7];
      wk_q <= wk_q | req.data[6];
      if (!lk) lo_q <= req.data[3:0];
    end
  end
  a_crit_frozen: assert property (ck_q |=> $stable(crit_trip))
    else $error("crit trip changed while locked");
  a_win_frozen: assert property (
    wk_q |=> $stable({upper_trip, lower_trip}))
    else $error("window changed while locked");
  a_trip_write: assert property (
    !ck_q && req.wr && req.addr == ACL_OFS_CRIT
    |=> crit_trip == ($past(req.data) & ACL_TRIP_MASK))
    else $error("crit trip write lost");
  a_lock_read: assert property (cfg_rd |-> rd_data[7:6] == {ck_q, wk_q})
    else $error("lock bits read wrong");
  a_clear_zero: assert property (cfg_rd |-> !rd_data[5])
    else $error("clear bit read nonzero");
  a_status_pin: assert property (
    cfg_rd |-> rd_data[4] == (alert_o == lo_q[1]))
    else $error("status differs from pin");
  a_cfg_frozen: assert property (cfg_rd |-> rd_data[3:0] == lo_q)
    else $error("low config bits wrong");
  a_out_off: assert property (!lo_q[3] |=> alert_o != lo_q[1])
    else $error("alert asserted while disabled");
  cover property (cfg_wr && req.data[7]);
  cover property (cfg_wr && req.data[5] && lo_q[0]);
  cover property (lo_q[3] && alert_o == lo_q[1]);
endmodule
bind acl_top acl_monitor acl_monitor_i (.ref_clk(ref_clk),
  .reset_n(reset_n), .req(req), .rd_data(rd_data), .cond(cond),
  .alert_o(alert_o), .alert_oe_n(alert_oe_n), .upper_trip(upper_trip),
  .lower_trip(lower_trip), .crit_trip(crit_trip));

/* File: test/acl_host_model.sv */
// host side model: register writes and read pointer
module acl_host_model import acl_pkg::*; (
  input wire logic ref_clk,
  output acl_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = 25'h0000000;
  // one-cycle strobe; data inverted once released
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    req <= '{wr: 1'b1, addr: a, data: d};
    @(negedge ref_clk);
    req <= '{wr: 1'b0, addr: a, data: ~d};
  endtask
  // pointer for a combinational read
  task automatic point(input logic [7:0] a);
    @(negedge ref_clk);
    req.addr <= a;
  endtask
endmodule

/* File: test/tb_acl_top.sv */
// self-checking bench of the alert configuration lock bank
module tb_acl_top;
  timeunit 1ns;
  timeprecision 1ps;
  import acl_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  acl_req_t    req;
  acl_cond_t   cond = 3'h0; // bit0 above crit, bit1 below, bit2 above
  logic [15:0] rd_data, up, lo, cr;
  logic        alert_o, oe_n;
  int          n_errors = 0;
  int          comparisons = 0;
  always #10 ref_clk = ~ref_clk;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
  acl_host_model acl_host_model_i (.ref_clk(ref_clk), .req(req));
  acl_top acl_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .req(req),
    .rd_data(rd_data), .cond(cond), .alert_o(alert_o),
    .alert_oe_n(oe_n), .upper_trip(up), .lower_trip(lo),
    .crit_trip(cr));
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    acl_host_model_i.point(a);
    #1 `CHK("rd_data", e, rd_data)
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    acl_host_model_i.wr(a, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic complete_run;
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    cyc(4);
    reset_n = 1'b1;
    rd(8'h01, 16'h0000);
    rd(8'h10, 16'h0000);
    `CHK("oe_n", 1'b0, oe_n)
    wr(8'h04, 16'hFFFF);
    `CHK("crit", 16'h1FFC, cr)
    wr(8'h02, 16'h0123);
    wr(8'h03, 16'h0456);
    wr(8'h01, 16'h003A); // enable, high polarity, clear, status
    rd(8'h01, 16'h000A);
    cyc(1);
    cond = 3'h2; // below window alone is a window source
    cyc(1);
    `CHK("alert", 1'b1, alert_o)
    rd(8'h01, 16'h001A);
    wr(8'h01, 16'h002A);
    `CHK("alert", 1'b1, alert_o)
    wr(8'h01, 16'h000C); // critical only, low polarity
    cond = 3'h4;
    cyc(2);
    `CHK("alert", 1'b1, alert_o)
    cond = 3'h1;
    cyc(2);
    `CHK("alert", 1'b0, alert_o)
    wr(8'h01, 16'h0000);
    cyc(2);
    `CHK("alert", 1'b1, alert_o)
    cond = 3'h0;
    wr(8'h01, 16'h0009); // latched interrupt mode
    cond = 3'h1;
    cyc(1);
    cond = 3'h0;
    cyc(3);
    `CHK("alert", 1'b0, alert_o)
    wr(8'h01, 16'h0029);
    cyc(2);
    `CHK("alert", 1'b1, alert_o)
    wr(8'h01, 16'h0080);
    rd(8'h01, 16'h0080);
    wr(8'h04, 16'h0000);
    `CHK("crit", 16'h1FFC, cr)
    wr(8'h01, 16'h004F);
    rd(8'h01, 16'h00C0);
    wr(8'h02, 16'hFFFF);
    wr(8'h03, 16'hFFFF);
    `CHK("window", 32'h01200454, {up, lo})
    reset_n = 1'b0;
    cyc(1);
    reset_n = 1'b1;
    rd(8'h01, 16'h0000);
    complete_run();
  end
endmodule
